// *** rtl/ogw_otp_write.sv ***
// Purpose: two-wire slave that programs otp cells and channel registers
// Assumes: scl and sda arrive asynchronously; core_clk samples both lines
// Notes:   outputs come from flops; sda is open drain, driven low when enabled
`timescale 1ns/1ps
module ogw_otp_write #(
  parameter logic [6:0] DEV_ADDR = ogw_pkg::DEV_ADDR_DEF
) (
  // clock and resets
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         otp_por_b,
  // two-wire bus pins
  input  wire logic         scl_pin,
  input  wire logic         sda_pin,
  output logic              sda_out,
  output logic              sda_oe,
  // channel values and lock state
  output ogw_pkg::ogw_bank_t chan_out,
  output logic              otp_locked
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ogw_pkg::ogw_state_t  state;
    logic [7:0]           sh;
    logic [3:0]           bitcnt;
    logic                 ack;
    logic [4:0]           code;
    logic                 first;
    logic [7:0]           hi;
    logic [7:0]           tx;
    logic                 sda_o;
    logic                 sda_oe;
    ogw_pkg::ogw_bank_t   bank;
    ogw_pkg::ogw_otp_wr_t wr;
    logic                 load_done;
    logic                 locked;
  } ogw_main_st_t;

  ogw_main_st_t       st_q;
  ogw_main_st_t       st_d;
  logic               scl_lvl;
  logic               scl_rise;
  logic               scl_fall;
  logic               sda_lvl;
  logic               sda_rise;
  logic               sda_fall;
  logic               start_seen;
  logic               stop_seen;
  logic               tx_state;
  logic               locked;
  ogw_pkg::ogw_bank_t otp_bank;

  // ----------------------------------------
  // pin synchronisers and otp cells
  // ----------------------------------------
  ogw_sync u_scl_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (scl_pin),
    .level    (scl_lvl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );

  ogw_sync u_sda_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pin_in   (sda_pin),
    .level    (sda_lvl),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );

  ogw_otp_cells u_cells (
    .core_clk (core_clk),
    .por_b    (otp_por_b),
    .wr       (st_q.wr),
    .bank     (otp_bank),
    .locked   (locked)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lock is a single-location target, so stepping never lands on it
  function automatic logic [4:0] next_code(input logic [4:0] code);
    if (code >= ogw_pkg::LOC_VCOM_B) begin
      return ogw_pkg::LOC_NONE;
    end
    return code + 5'h01;
  endfunction

  // read word for a location, lock bit shows in bit zero
  function automatic logic [15:0] read_word(input logic [4:0] code, input ogw_pkg::ogw_bank_t bank,
                                            input logic lock);
    logic [15:0] w;
    w = 16'h0000;
    if (code == ogw_pkg::LOC_LOCK) begin
      w[ogw_pkg::LOCK_BIT] = lock;
    end else if (ogw_pkg::ogw_is_chan(code)) begin
      w[ogw_pkg::VAL_W-1:0] = bank[ogw_pkg::ogw_loc_index(code)];
    end
    return w;
  endfunction

  function automatic logic loc_ok(input logic [7:0] b);
    return (b[7:5] == ogw_pkg::LOC_TOP_ZERO) &&
           (ogw_pkg::ogw_is_chan(b[4:0]) || b[4:0] == ogw_pkg::LOC_LOCK);
  endfunction

  // start and stop: sda moves while scl is high
  assign start_seen = scl_lvl & sda_fall;
  assign stop_seen  = scl_lvl & sda_rise;
  assign tx_state   = (st_q.state == ogw_pkg::ST_RHI) || (st_q.state == ogw_pkg::ST_RLO);

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    logic [ogw_pkg::VAL_W-1:0] val;
    logic [ogw_pkg::IDX_W-1:0] idx;
    logic [15:0]               word;
    val        = '0;
    idx        = '0;
    word       = '0;
    st_d       = st_q;
    st_d.wr.en = 1'b0;
    st_d.sda_o = 1'b0;
    st_d.locked = locked;

    // first cycle after reset copies otp into the channels
    if (!st_q.load_done) begin
      st_d.bank      = otp_bank;
      st_d.load_done = 1'b1;
    end

    if (start_seen) begin
      // a half-received set is simply dropped
      st_d.state  = ogw_pkg::ST_DEV;
      st_d.bitcnt = '0;
      st_d.ack    = 1'b0;
      st_d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      st_d.state  = ogw_pkg::ST_IDLE;
      st_d.ack    = 1'b0;
      st_d.sda_oe = 1'b0;
    end else if (st_q.state != ogw_pkg::ST_IDLE && st_q.state != ogw_pkg::ST_SKIP) begin
      if (scl_rise) begin
        if (!st_q.ack) begin
          st_d.sh     = {st_q.sh[6:0], sda_lvl};
          st_d.bitcnt = st_q.bitcnt + 4'h1;
        end else if (tx_state && sda_lvl && !st_q.sda_oe) begin
          // master did not acknowledge: read is over
          st_d.state = ogw_pkg::ST_SKIP;
        end
      end else if (scl_fall) begin
        if (st_q.ack) begin
          st_d.ack    = 1'b0;
          st_d.bitcnt = '0;
          st_d.sda_oe = 1'b0;
          if (tx_state) begin
            st_d.sda_oe = ~st_q.tx[7];
            st_d.tx     = {st_q.tx[6:0], 1'b0};
          end
        end else if (st_q.bitcnt == ogw_pkg::BITS_PER_BYTE) begin
          st_d.ack    = 1'b1;
          st_d.sda_oe = 1'b1;
          unique case (st_q.state)
            ogw_pkg::ST_DEV: begin
              if (st_q.sh[7:1] == DEV_ADDR) begin
                word = read_word(st_q.code, st_q.bank, st_q.locked);
                st_d.tx    = word[15:8];
                st_d.state = st_q.sh[0] ? ogw_pkg::ST_RHI : ogw_pkg::ST_LOC;
              end else begin
                st_d.sda_oe = 1'b0;
                st_d.state  = ogw_pkg::ST_SKIP;
              end
            end
            ogw_pkg::ST_LOC: begin
              if (loc_ok(st_q.sh)) begin
                st_d.code  = st_q.sh[4:0];
                st_d.first = 1'b1;
                st_d.state = ogw_pkg::ST_DHI;
              end else begin
                st_d.sda_oe = 1'b0;
                st_d.state  = ogw_pkg::ST_SKIP;
              end
            end
            ogw_pkg::ST_DHI: begin
              st_d.hi    = st_q.sh;
              st_d.state = ogw_pkg::ST_DLO;
            end
            ogw_pkg::ST_DLO: begin
              // set is complete only here
              val = {st_q.hi[1:0], st_q.sh};
              idx = ogw_pkg::ogw_loc_index(st_q.code);
              if (ogw_pkg::ogw_is_chan(st_q.code) || (st_q.code == ogw_pkg::LOC_LOCK && st_q.first)) begin
                if (st_q.hi[ogw_pkg::SEL_HI:ogw_pkg::SEL_LO] == ogw_pkg::OTP_SEL) begin
                  if (!locked) begin
                    st_d.wr.en   = 1'b1;
                    st_d.wr.code = st_q.code;
                    st_d.wr.val  = val;
                    if (ogw_pkg::ogw_is_chan(st_q.code)) begin
                      st_d.bank[idx] = otp_bank[idx] | val;
                    end
                  end
                end else if (ogw_pkg::ogw_is_chan(st_q.code)) begin
                  st_d.bank[idx] = val;
                end
              end
              st_d.code  = next_code(st_q.code);
              st_d.first = 1'b0;
              st_d.state = ogw_pkg::ST_DHI;
            end
            ogw_pkg::ST_RHI: begin
              word        = read_word(st_q.code, st_q.bank, st_q.locked);
              st_d.sda_oe = 1'b0;
              st_d.tx     = word[7:0];
              st_d.state  = ogw_pkg::ST_RLO;
            end
            ogw_pkg::ST_RLO: begin
              word        = read_word(next_code(st_q.code), st_q.bank, st_q.locked);
              st_d.sda_oe = 1'b0;
              st_d.code   = next_code(st_q.code);
              st_d.tx     = word[15:8];
              st_d.state  = ogw_pkg::ST_RHI;
            end
            default: begin
              st_d.sda_oe = 1'b0;
              st_d.state  = ogw_pkg::ST_IDLE;
            end
          endcase
        end else if (tx_state) begin
          st_d.sda_oe = ~st_q.tx[7];
          st_d.tx     = {st_q.tx[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sda_out    = st_q.sda_o;
  assign sda_oe     = st_q.sda_oe;
  assign chan_out   = st_q.bank;
  assign otp_locked = st_q.locked;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_data_hi_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DHI && st_q.state == ogw_pkg::ST_DLO) |-> st_q.sda_oe && st_q.ack)
    else $error("data byte not acknowledged");

  chk_bad_loc_nack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_LOC && st_q.state == ogw_pkg::ST_SKIP) |-> !st_q.sda_oe)
    else $error("refused location was acknowledged");

  chk_skip_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q.state == ogw_pkg::ST_SKIP) |=> !st_q.wr.en)
    else $error("write while ignoring bytes");

  chk_write_on_low: assert property (@(posedge core_clk) disable iff (!rst_b)
    st_q.wr.en |-> $past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI)
    else $error("otp write without a complete set");

  chk_stop_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    (stop_seen || start_seen) |=> !st_q.wr.en ##1 !st_q.wr.en)
    else $error("write after stop or start");

  chk_otp_to_chan: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q.wr.en && ogw_pkg::ogw_is_chan(st_q.wr.code)) |->
      st_q.bank[ogw_pkg::ogw_loc_index(st_q.wr.code)] ==
        (otp_bank[ogw_pkg::ogw_loc_index(st_q.wr.code)] | st_q.wr.val))
    else $error("channel not loaded with otp value");

  chk_lock_single: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_q.wr.en && st_q.wr.code == ogw_pkg::LOC_LOCK) |-> $past(st_q.first))
    else $error("lock written by stepping");

  chk_locked_reject: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(locked) |-> !st_q.wr.en)
    else $error("otp write while locked");

  chk_step_skips_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI) |-> st_q.code != ogw_pkg::LOC_LOCK)
    else $error("sequence stepped onto lock");

  chk_powerup_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(st_q.load_done) |-> st_q.bank == $past(otp_bank))
    else $error("channels not loaded from otp");

  chk_data_lo_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI) |-> st_q.sda_oe && st_q.ack)
    else $error("low data byte not acknowledged");

  chk_work_no_otp: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI &&
     $past(st_q.hi[ogw_pkg::SEL_HI:ogw_pkg::SEL_LO]) != ogw_pkg::OTP_SEL) |-> !st_q.wr.en)
    else $error("working register write reached otp");

  chk_walk_ends: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI &&
     $past(st_q.code) == ogw_pkg::LOC_VCOM_B) |-> st_q.code == ogw_pkg::LOC_NONE)
    else $error("sequence went on past the last channel");

  chk_gap_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    ($past(st_q.state) == ogw_pkg::ST_DLO && st_q.state == ogw_pkg::ST_DHI &&
     $past(st_q.code) > ogw_pkg::LOC_CH_LAST && $past(st_q.code) < ogw_pkg::LOC_VCOM_A) |-> !st_q.wr.en)
    else $error("unused location was written");

endmodule

// *** rtl/ogw_pkg.sv ***
// Purpose: shared constants, types and helpers for the two-wire OTP write block
// Assumes: location codes are five bits wide; channel values are ten bits wide
// Notes:   the device address default is arbitrary and carries no meaning
package ogw_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int          NUM_CHAN      = 16;
  localparam int          VAL_W         = 10;
  localparam int          IDX_W         = 4;

  // ----------------------------------------
  // location codes
  // ----------------------------------------
  localparam logic [4:0]  LOC_CH_LAST   = 5'h0d;
  localparam logic [4:0]  LOC_VCOM_A    = 5'h12;
  localparam logic [4:0]  LOC_VCOM_B    = 5'h13;
  localparam logic [4:0]  LOC_LOCK      = 5'h14;  // otp_write_lock location
  localparam logic [4:0]  LOC_NONE      = 5'h1f;
  localparam logic [4:0]  VCOM_SKIP     = 5'h04;
  localparam logic [2:0]  LOC_TOP_ZERO  = 3'h0;

  // ----------------------------------------
  // byte framing and field layout
  // ----------------------------------------
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [1:0]  OTP_SEL       = 2'h1;
  localparam int          SEL_HI        = 7;
  localparam int          SEL_LO        = 6;
  localparam int          LOCK_BIT      = 0;
  localparam logic [6:0]  DEV_ADDR_DEF  = 7'h2a;  // arbitrary value

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic [NUM_CHAN-1:0][VAL_W-1:0] ogw_bank_t;

  typedef struct packed {
    logic             en;
    logic [4:0]       code;
    logic [VAL_W-1:0] val;
  } ogw_otp_wr_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_LOC  = 3'h2,
    ST_DHI  = 3'h3,
    ST_DLO  = 3'h4,
    ST_RHI  = 3'h5,
    ST_RLO  = 3'h6,
    ST_SKIP = 3'h7
  } ogw_state_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic ogw_is_chan(input logic [4:0] code);
    return (code <= LOC_CH_LAST) || (code == LOC_VCOM_A) || (code == LOC_VCOM_B);
  endfunction

  function automatic logic [IDX_W-1:0] ogw_loc_index(input logic [4:0] code);
    logic [4:0] shifted;
    shifted = code - VCOM_SKIP;
    if (code <= LOC_CH_LAST) begin
      return code[IDX_W-1:0];
    end
    return shifted[IDX_W-1:0];
  endfunction

endpackage

// *** rtl/ogw_sync.sv ***
// Purpose: two-stage synchroniser for a bus pin with edge pulses
// Assumes: the pin is slow against core_clk (eight samples per bit or more)
// Notes:   first stage feeds only the second; edges come from stages two and three
`timescale 1ns/1ps
module ogw_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // pin side
  input  wire logic pin_in,
  // core side
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ogw_sync_st_t;

  ogw_sync_st_t st_q;
  ogw_sync_st_t st_d;

  // ----------------------------------------
  // shift chain
  // ----------------------------------------
  always_comb begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  // idle bus is high, so reset to high avoids a false edge at release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  // edges look only at settled stages
  assign level = st_q.s2;
  assign rise  = st_q.s2 & ~st_q.s3;
  assign fall  = ~st_q.s2 & st_q.s3;

endmodule

// *** rtl/ogw_otp_cells.sv ***
// Purpose: one-time-programmable cells for sixteen channels and the lock bit
// Assumes: por_b models a blank die only; it is not the logic reset
// Notes:   cells can only be set, never cleared
`timescale 1ns/1ps
module ogw_otp_cells (
  // clock and power-on
  input  wire logic               core_clk,
  input  wire logic               por_b,
  // write request
  input  wire ogw_pkg::ogw_otp_wr_t wr,
  // stored contents
  output ogw_pkg::ogw_bank_t      bank,
  output logic                    locked
);

  typedef struct packed {
    ogw_pkg::ogw_bank_t bank;
    logic               lock;
  } ogw_otp_st_t;

  ogw_otp_st_t st_q;
  ogw_otp_st_t st_d;

  // ----------------------------------------
  // set-only programming
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (wr.en && !st_q.lock) begin
      if (wr.code == ogw_pkg::LOC_LOCK) begin
        st_d.lock = st_q.lock | wr.val[ogw_pkg::LOCK_BIT];
      end else if (ogw_pkg::ogw_is_chan(wr.code)) begin
        // or-in keeps programmed ones, a fuse cannot heal
        st_d.bank[ogw_pkg::ogw_loc_index(wr.code)] =
          st_q.bank[ogw_pkg::ogw_loc_index(wr.code)] | wr.val;
      end
    end
  end

  always_ff @(posedge core_clk or negedge por_b) begin
    if (!por_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bank   = st_q.bank;
  assign locked = st_q.lock;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_bits_stay_set: assert property (@(posedge core_clk) disable iff (!por_b)
    ((st_q.bank & $past(st_q.bank)) == $past(st_q.bank)))
    else $error("programmed otp bit returned to zero");

  chk_lock_freezes: assert property (@(posedge core_clk) disable iff (!por_b)
    $past(st_q.lock) |-> (st_q.bank == $past(st_q.bank)) && st_q.lock)
    else $error("otp changed while locked");

endmodule

// *** tb/ogw_master.sv ***
// Purpose: behavioural two-wire bus master that drives the otp write block
// Assumes: scl half period of four core_clk cycles; sda has a pull-up
// Notes:   lines change only at the falling edge of the core clock
`timescale 1ns/1ps
module ogw_master (
  // clock
  input  wire logic clk,
  // bus lines
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  // ----------------------------------------
  // bus idle: both lines released, scl stands still between frames
  // ----------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // nine clocks; a one in tx releases sda so the slave may answer
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~tx[i];
      half();
      scl = 1'b1;
      repeat (2) @(negedge clk);
      rx[i] = sda_wire;
      repeat (2) @(negedge clk);
      scl = 1'b0;
    end
    sda_low = 1'b0;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the two-wire otp write block
// Assumes: blank cells at time zero; bus master model in ogw_master
// Notes:   expected channel values follow the set-only cell behaviour
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  localparam logic [6:0] DEV = ogw_pkg::DEV_ADDR_DEF;
  logic               core_clk;
  logic               rst_b;
  logic               otp_por_b;
  logic               scl;
  logic               m_low;
  logic               sda_out;
  logic               sda_oe;
  logic               sda_wire;
  logic               otp_locked;
  ogw_pkg::ogw_bank_t chan_out;
  int                 error_cnt;
  int                 checks;
  logic [8:0]         rx;

  // ----------------------------------------
  // wiring: open drain sda with pull-up
  // ----------------------------------------
  assign sda_wire = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  ogw_otp_write #(.DEV_ADDR(DEV)) dut_u (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .otp_por_b  (otp_por_b),
    .scl_pin    (scl),
    .sda_pin    (sda_wire),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .chan_out   (chan_out),
    .otp_locked (otp_locked)
  );

  ogw_master mst_u (
    .clk      (core_clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_low  (m_low)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared bus helpers
  // ----------------------------------------
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [8:0] r;
    mst_u.byte9({b, 1'b1}, r);
    `CHK(~r[0], exp_ack)
  endtask

  // write direction bit always low here, location byte sent as given
  task automatic open_loc(input logic [7:0] loc, input logic exp_ack);
    mst_u.start();
    send({DEV, 1'b0}, 1'b1);
    send(loc, exp_ack);
  endtask

  task automatic put_set(input logic [7:0] hi, input logic [7:0] lo);
    send(hi, 1'b1);
    send(lo, 1'b1);
  endtask

  // logic reset only, cells keep their contents
  task automatic core_reset();
    rst_b = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_seq();
    open_loc(8'h00, 1'b1);
    for (int i = 0; i < 20; i++) begin
      put_set(8'h41, 8'(i));
    end
    put_set(8'h41, 8'hff);
    mst_u.stop();
    for (int k = 0; k < 14; k++) begin
      `CHK(chan_out[k], 10'h100 | 10'(k))
    end
    `CHK(chan_out[14], 10'h112)
    `CHK(chan_out[15], 10'h113)
    `CHK(otp_locked, 1'b0)
    $display("test seq done");
  endtask

  // high byte alone must not commit; cells only gain ones
  task automatic t_single();
    open_loc(8'h02, 1'b1);
    send(8'h41, 1'b1);
    repeat (6) @(negedge core_clk);
    `CHK(chan_out[2], 10'h102)
    send(8'h21, 1'b1);
    mst_u.stop();
    `CHK(chan_out[2], 10'h123)
    $display("test single done");
  endtask

  task automatic t_abort();
    open_loc(8'h05, 1'b1);
    put_set(8'h42, 8'h00);
    send(8'h43, 1'b1);
    mst_u.stop();
    `CHK(chan_out[5], 10'h305)
    `CHK(chan_out[6], 10'h106)
    $display("test abort done");
  endtask

  // other selectors touch only the working registers, lost on reset
  task automatic t_work();
    open_loc(8'h04, 1'b1);
    put_set(8'h00, 8'h0f);
    put_set(8'h81, 8'h0e);
    put_set(8'hc0, 8'h0d);
    mst_u.stop();
    `CHK(chan_out[4], 10'h00f)
    `CHK(chan_out[5], 10'h10e)
    `CHK(chan_out[6], 10'h00d)
    core_reset();
    `CHK(chan_out[4], 10'h104)
    `CHK(chan_out[5], 10'h305)
    `CHK(chan_out[6], 10'h106)
    $display("test work done");
  endtask

  task automatic t_refuse();
    for (int c = 0; c < 32; c++) begin
      open_loc(8'(c), (c <= 13) || (c >= 18 && c <= 20));
      mst_u.stop();
    end
    open_loc(8'h2d, 1'b0);
    send(8'h43, 1'b0);
    send(8'hff, 1'b0);
    mst_u.stop();
    `CHK(chan_out[13], 10'h10d)
    $display("test refuse done");
  endtask

  // lock is set last, once programming is finished
  task automatic t_lock();
    open_loc(8'h14, 1'b1);
    put_set(8'h41, 8'hfe);
    mst_u.stop();
    `CHK(otp_locked, 1'b0)
    open_loc(8'h14, 1'b1);
    put_set(8'h40, 8'h01);
    mst_u.stop();
    `CHK(otp_locked, 1'b1)
    open_loc(8'h00, 1'b1);
    put_set(8'h43, 8'hff);
    mst_u.stop();
    `CHK(chan_out[0], 10'h100)
    open_loc(8'h14, 1'b1);
    mst_u.start();
    mst_u.byte9({DEV, 1'b1, 1'b1}, rx);
    `CHK(rx[0], 1'b0)
    mst_u.byte9(9'h1fe, rx);
    `CHK(rx[8:1], 8'h00)
    mst_u.byte9(9'h1ff, rx);
    `CHK(rx[1], 1'b1)
    mst_u.stop();
    core_reset();
    `CHK(otp_locked, 1'b1)
    $display("test lock done");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_b = 1'b0;
    otp_por_b = 1'b0;
    repeat (3) @(negedge core_clk);
    otp_por_b = 1'b1;
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int k = 0; k < 16; k++) begin
      `CHK(chan_out[k], 10'h000)
    end
    t_seq();
    t_single();
    t_abort();
    t_work();
    t_refuse();
    t_lock();
    tally_and_finish();
  end

  // about four times the expected run length
  initial begin
    #5000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
